// file: shared/pmic_irq_pkg.sv
// constants and carrier types for the event and interrupt block
// assumes one 100 mhz clock; registers sit at word index times four on apb
package pmic_irq_pkg;
	// clock rate and ldo limit dwell time
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LDO_LIMIT_MS = 10;
	// more than 10 ms: count whole cycles, event fires one past the figure
	localparam int unsigned LDO_LIMIT_CYC = (CLK_HZ / 1000) * LDO_LIMIT_MS;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_EV_SUPPLY = 8'h07;
	localparam logic [7:0] IDX_EV_GI_LO = 8'h08;
	localparam logic [7:0] IDX_EV_GI_HI = 8'h09;
	localparam logic [7:0] IDX_MASK_SYS = 8'h0a;
	localparam logic [7:0] IDX_MASK_SUPPLY = 8'h0b;
	localparam logic [7:0] IDX_MASK_GI_LO = 8'h0c;
	localparam logic [7:0] IDX_SUMMARY = 8'h11;
	localparam logic [7:0] IDX_ACT_LO = 8'h12;
	localparam logic [7:0] IDX_ACT_HI = 8'h13;
	localparam logic [7:0] IDX_CTRL = 8'h14;

	// supply event bit positions
	localparam int unsigned B_VDD_WARN = 7;
	localparam int unsigned B_VDD_MON = 6;
	localparam int unsigned B_RAMP = 5;
	localparam int unsigned B_REG = 4;
	localparam int unsigned B_LDO = 3;
	localparam int unsigned B_COMP = 2;
	localparam int unsigned B_TEMP = 1;
	localparam int unsigned B_WAKE = 0;
	// alternate sources in the high general-input register
	localparam int unsigned B_TWO_WIRE = 6;
	// summary register bits
	localparam int unsigned B_SUM_SUPPLY = 5;
	localparam int unsigned B_STARTUP = 0;
	// control register: regulator monitor mode select
	localparam int unsigned B_REG_MODE = 0;

	// reset values
	localparam logic [7:0] RST_EVENT = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_ACT = 8'hff;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// only bits 4:0 of the system mask exist
	localparam logic [7:0] MASK_SYS_USED = 8'h1f;

	// monitor signals arriving from analog and pin logic
	typedef struct packed {
		logic supply_below_warn; // below upper fault warning level
		logic supply_below_mon; // below programmable monitor level
		logic ramp_busy; // any dynamic_voltage_ramp running
		logic reg_out_of_range; // monitored regulator out of range
		logic reg_meas_ready; // new regulator measurement toggle
		logic [4:0] ldo_at_limit; // current-limited ldos at limit
		logic comparator_out; // 1.2 v comparator state
		logic temp_high; // junction temperature high
		logic charger_wake_input;
		logic powerup_done; // power-up sequence finished
		logic [15:0] general_input;
		logic [2:0] adc_above_high; // adc_input_one..three indicators
		logic fast_two_wire_port_hit; // host addressed fast port
		logic [2:0] domain_enable_port; // system, power, power1
	} monitor_s;

	localparam int unsigned MON_W = $bits(monitor_s);
endpackage

// file: rtl/bit_sync.sv
// two-stage synchroniser, one per bit of a vector
// assumes inputs are asynchronous to clk_i; reset to zero
`timescale 1ns/1ps
module bit_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// one synchroniser chain per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q; // first stage, read only by second
		logic sync_q; // second stage
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= d_i[i];
				sync_q <= meta_q;
			end
		end
		assign q_o[i] = sync_q;
	end
endmodule

// file: rtl/limit_timer.sv
// dwell timer: one pulse when a level has stayed high past a count
// assumes level_i is already synchronised to clk_i
`timescale 1ns/1ps
module limit_timer #(
	parameter int unsigned LIMIT_CYC = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	output logic fire_o
);
	localparam int unsigned CW = $clog2(LIMIT_CYC + 2);
	localparam logic [CW-1:0] LIM = CW'(LIMIT_CYC);
	logic [CW-1:0] cnt_q; // cycles spent at limit
	logic fire_q; // one-cycle pulse

	// count while high, stop once past limit so it fires only once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			fire_q <= 1'b0;
		end else if (!level_i) begin
			cnt_q <= '0;
			fire_q <= 1'b0;
		end else begin
			if (cnt_q <= LIM) begin
				cnt_q <= cnt_q + 1'b1;
			end
			fire_q <= (cnt_q == LIM);
		end
	end
	assign fire_o = fire_q;
endmodule

// file: rtl/pmic_event_irq_logic.sv
// event latching, masking and interrupt line of the power manager
// assumes an apb master on CLOCK_I and monitor levels from other domains
//
// Notes on behaviour
// R1 - host writes back read value to clear
// R2 - line held until all events cleared
// R3 - supply warning fall sets bit 7
// R4 - monitor threshold crossing either way sets 6
// R5 - all ramps finished sets bit 5
// R6 - regulator range or measurement sets 4
// R7 - ldo at limit over 10 ms sets 3
// R8 - comparator event sets bit 2
// R9 - high junction temperature sets bit 1
// R10 - charger wake rising edge sets 0
// R11 - general inputs 7..0, adc thresholds on 2..0
// R12 - general inputs 15..8, fast port on 6
// R13 - domain enable ports on high bits 2..0
// R14 - system mask bits 4..0, upper reserved
// R15 - supply mask one bit per event
// R16 - general input low mask per bit
// R17 - line active when unmasked event set
// R18 - events during clearing held, then latched
// R19 - line masked through power-up until cleared
// R20 - summary bit while supply events pending
// R21 - masked events still latched and readable
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module pmic_event_irq_logic
	import pmic_irq_pkg::*;
#(
	parameter int unsigned LDO_LIMIT_CYCLES = LDO_LIMIT_CYC
) (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire monitor_s MON_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic INTERRUPT_REQUEST_LINE_N_O,
	output logic [4:0] SYSTEM_MASK_O
);
	// synchronised and previous monitor levels
	logic [MON_W-1:0] mon_raw; // flattened pin levels
	logic [MON_W-1:0] mon_flat; // after two flops
	monitor_s s; // current synchronised view
	monitor_s p_q; // previous cycle view

	// edge and event terms
	logic ldo_any; // any ldo at its limit
	logic ldo_fire; // limit held past dwell time
	logic [15:0] gi_act_now; // inputs in active state now
	logic [15:0] gi_act_prev; // inputs in active state before
	logic [15:0] gi_hit; // entered active state
	logic [2:0] dom_act_now; // domain ports active now
	logic [2:0] dom_act_prev;
	logic [7:0] new_ev [3]; // fresh events per register

	// software registers
	logic [7:0] ev_q [3]; // supply, gi low, gi high events
	logic [7:0] pend_q [3]; // events held over a clear
	logic [7:0] mask_sys_q; // system event mask
	logic [7:0] mask_sup_q; // supply event mask
	logic [7:0] mask_gi_q; // general input low mask
	logic [15:0] act_q; // active level per general input
	logic [7:0] ctrl_q; // regulator monitor mode
	logic startup_q; // line held off after reset
	logic host_wrote_q; // a clearing write has happened

	// apb handshake
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic irq_n_q;
	logic [4:0] sys_mask_o_q;
	logic access; // access phase
	logic commit; // write or read takes effect
	logic [7:0] idx; // word index from address
	logic hit; // address maps to a register
	logic wr; // committed write
	logic [7:0] rd_val; // read mux result
	logic [7:0] clr [3]; // clear masks per event register
	logic [2:0] clr_act; // clear in progress per register
	logic [7:0] idx_ev [3]; // event register indices
	logic [7:0] gate [3]; // mask per event register
	logic any_unmasked; // drives the line
	logic all_clear; // no event bit anywhere

	// event register indices, one per generate entry below
	assign idx_ev[0] = IDX_EV_SUPPLY;
	assign idx_ev[1] = IDX_EV_GI_LO;
	assign idx_ev[2] = IDX_EV_GI_HI;

	// every monitor level crosses into the clock domain
	assign mon_raw = MON_I;
	bit_sync #(
		.W(MON_W)
	) u_sync (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.d_i(mon_raw),
		.q_o(mon_flat)
	);
	assign s = monitor_s'(mon_flat);

	// previous view for edge detection, reads only synced levels
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			p_q <= '0;
		end else begin
			// reset to zero matches the idle level of the synced bits
			p_q <= s;
		end
	end

	// dwell timer for the current-limited ldos
	// any one ldo at its limit keeps the timer running
	assign ldo_any = |s.ldo_at_limit;
	limit_timer #(
		.LIMIT_CYC(LDO_LIMIT_CYCLES)
	) u_ldo_timer (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.level_i(ldo_any), // [R7]
		.fire_o(ldo_fire)
	);

	// active-state decode: act bit 1 means active high
	assign gi_act_now = ~(s.general_input ^ act_q);
	assign gi_act_prev = ~(p_q.general_input ^ act_q);
	// both views use the same setting, so a polarity write alone raises no event
	assign gi_hit = gi_act_now & ~gi_act_prev;
	assign dom_act_now = ~(s.domain_enable_port ^ act_q[10:8]);
	assign dom_act_prev = ~(p_q.domain_enable_port ^ act_q[10:8]);

	// supply and monitor event sources
	always_comb begin
		new_ev[0] = 8'h00;
		// dropping below the warning level
		new_ev[0][B_VDD_WARN] = s.supply_below_warn & ~p_q.supply_below_warn; // [R3]
		// either direction across the monitor level
		new_ev[0][B_VDD_MON] = s.supply_below_mon ^ p_q.supply_below_mon; // [R4]
		// last ramp finishing
		new_ev[0][B_RAMP] = ~s.ramp_busy & p_q.ramp_busy; // [R5]
		// mode picks range fault or new measurement
		if (ctrl_q[B_REG_MODE]) begin
			new_ev[0][B_REG] = s.reg_meas_ready ^ p_q.reg_meas_ready; // [R6]
		end else begin
			new_ev[0][B_REG] = s.reg_out_of_range & ~p_q.reg_out_of_range; // [R6]
		end
		// dwell timer already gives a single pulse
		new_ev[0][B_LDO] = ldo_fire; // [R7]
		// comparator output change in either sense
		new_ev[0][B_COMP] = s.comparator_out ^ p_q.comparator_out; // [R8]
		// entering the hot state only
		new_ev[0][B_TEMP] = s.temp_high & ~p_q.temp_high; // [R9]
		// rising edge only; falling edge is ignored
		new_ev[0][B_WAKE] = s.charger_wake_input & ~p_q.charger_wake_input; // [R10]
	end

	// general input event sources with alternate functions
	always_comb begin
		new_ev[1] = gi_hit[7:0]; // [R11]
		// adc threshold crossings, high or low, share bits 2..0
		new_ev[1][2:0] = gi_hit[2:0] | (s.adc_above_high ^ p_q.adc_above_high); // [R11]
		new_ev[2] = gi_hit[15:8]; // [R12]
		new_ev[2][B_TWO_WIRE] = gi_hit[14]
			| (s.fast_two_wire_port_hit & ~p_q.fast_two_wire_port_hit); // [R12]
		// shared domain enable ports follow the same active setting
		new_ev[2][2:0] = gi_hit[10:8] | (dom_act_now & ~dom_act_prev); // [R13]
	end

	// apb decode; one wait state, answer registered
	assign access = PSEL_I & PENABLE_I;
	assign commit = access & pready_q;
	assign idx = PADDR_I[9:2];
	assign wr = commit & PWRITE_I & hit;

	// address hit for mapped word indices; low address bits ignored
	always_comb begin
		hit = 1'b0;
		// upper address bits select other blocks; only zero decodes here
		if (PADDR_I[11:10] == 2'b00) begin
			unique case (idx)
				IDX_EV_SUPPLY, IDX_EV_GI_LO, IDX_EV_GI_HI: hit = 1'b1;
				IDX_MASK_SYS, IDX_MASK_SUPPLY, IDX_MASK_GI_LO: hit = 1'b1;
				IDX_SUMMARY, IDX_ACT_LO, IDX_ACT_HI, IDX_CTRL: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
	end

	// pready rises one cycle into the access phase, then drops
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			// the toggle keeps ready low in the first access cycle
			pready_q <= access & ~pready_q;
			// unmapped address answers with an error
			pslverr_q <= access & ~pready_q & ~hit;
		end
	end

	// plain read-write registers
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			mask_sys_q <= RST_MASK;
			mask_sup_q <= RST_MASK;
			mask_gi_q <= RST_MASK;
			act_q <= {RST_ACT, RST_ACT};
			ctrl_q <= RST_CTRL;
		end else if (wr) begin
			unique case (idx)
				// reserved upper bits never store
				IDX_MASK_SYS: mask_sys_q <= PWDATA_I[7:0] & MASK_SYS_USED; // [R14]
				IDX_MASK_SUPPLY: mask_sup_q <= PWDATA_I[7:0]; // [R15]
				IDX_MASK_GI_LO: mask_gi_q <= PWDATA_I[7:0]; // [R16]
				// active level per input, one means active high
				IDX_ACT_LO: act_q[7:0] <= PWDATA_I[7:0];
				IDX_ACT_HI: act_q[15:8] <= PWDATA_I[7:0];
				// only the mode bit exists; the rest read back zero
				IDX_CTRL: ctrl_q[B_REG_MODE] <= PWDATA_I[B_REG_MODE];
				default: ;
			endcase
		end
	end

	// event registers: clear by write-back, hold new events over clear
	for (genvar r = 0; r < 3; r++) begin : g_ev
		// clear exactly the written ones of this register
		assign clr_act[r] = wr & (idx == idx_ev[r]);
		assign clr[r] = clr_act[r] ? PWDATA_I[7:0] : 8'h00; // [R1]

		always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
			if (SYS_RST_I) begin
				ev_q[r] <= RST_EVENT;
				pend_q[r] <= RST_EVENT;
			end else if (clr_act[r]) begin
				// park fresh events so the host sees them next read
				ev_q[r] <= (ev_q[r] & ~clr[r]) | pend_q[r]; // [R1]
				// a new event in the clear cycle is parked, never dropped
				pend_q[r] <= new_ev[r]; // [R18]
			end else begin
				// masks do not gate latching, only the line
				ev_q[r] <= ev_q[r] | new_ev[r] | pend_q[r]; // [R21]
				pend_q[r] <= 8'h00; // [R18]
			end
		end
	end

	// mask per register; high register has no mask here, so unmasked
	assign gate[0] = mask_sup_q;
	assign gate[1] = mask_gi_q;
	// its own mask lives outside this block
	assign gate[2] = 8'h00;

	// line source and global empty state
	assign any_unmasked = |(ev_q[0] & ~gate[0]) | |(ev_q[1] & ~gate[1])
		| |(ev_q[2] & ~gate[2]); // [R17]
	assign all_clear = ~(|ev_q[0] | |ev_q[1] | |ev_q[2]
		| |pend_q[0] | |pend_q[1] | |pend_q[2]); // [R2]

	// power-up hold: released once powered up and host cleared all
	// any event write counts, even one that clears nothing
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			host_wrote_q <= 1'b0;
		end else if (|clr_act) begin
			host_wrote_q <= 1'b1;
		end
	end
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			startup_q <= 1'b1;
		// limitation: a host that never writes keeps the line quiet
		end else if (s.powerup_done & host_wrote_q & all_clear) begin
			startup_q <= 1'b0; // [R19]
		end
	end

	// active-low line, flopped; stays low until all unmasked are cleared
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			irq_n_q <= 1'b1;
		end else begin
			// one flop after the event bit, so the pin never glitches
			irq_n_q <= ~(any_unmasked & ~startup_q); // [R2] [R17] [R19]
		end
	end

	// system mask drives other logic through its own pin flop, one cycle after the register
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sys_mask_o_q <= RST_MASK[4:0];
		end else begin
			// reserved bits stay inside; only five pins leave
			sys_mask_o_q <= mask_sys_q[4:0]; // [R14]
		end
	end

	// read mux; reserved and unmapped read as zero
	always_comb begin
		rd_val = 8'h00;
		unique case (idx)
			IDX_EV_SUPPLY: rd_val = ev_q[0];
			IDX_EV_GI_LO: rd_val = ev_q[1];
			IDX_EV_GI_HI: rd_val = ev_q[2];
			IDX_MASK_SYS: rd_val = mask_sys_q;
			IDX_MASK_SUPPLY: rd_val = mask_sup_q;
			IDX_MASK_GI_LO: rd_val = mask_gi_q;
			IDX_SUMMARY: begin
				rd_val[B_SUM_SUPPLY] = |ev_q[0]; // [R20]
				rd_val[B_STARTUP] = startup_q;
			end
			IDX_ACT_LO: rd_val = act_q[7:0];
			IDX_ACT_HI: rd_val = act_q[15:8];
			IDX_CTRL: rd_val = ctrl_q;
			default: rd_val = 8'h00;
		endcase
		// nonzero upper address bits also read zero
		if (!hit) begin
			rd_val = 8'h00;
		end
	end

	// read data captured as pready rises, held until next read access
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			prdata_q <= 32'h0000_0000;
		end else if (access & ~pready_q & ~PWRITE_I) begin
			// taken one edge before ready; an event latched then shows next read
			prdata_q <= {24'h00_0000, rd_val};
		end
	end

	// every output comes straight from a flop
	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign INTERRUPT_REQUEST_LINE_N_O = irq_n_q;
	assign SYSTEM_MASK_O = sys_mask_o_q;
endmodule

// file: tb/pmic_irq_props.sv
// assertions on the apb answer, mask pins and irq line of the event block
// assumes binding into pmic_event_irq_logic; sees its ports only
`timescale 1ns/1ps
module pmic_irq_props (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic INTERRUPT_REQUEST_LINE_N_O,
	input wire logic [4:0] SYSTEM_MASK_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	wire wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I; // write lands now
	logic ev_wr_q; // host has written an event register
	logic [2:0] age_q; // cycles since last write, saturates
	// remembers the first clearing write after reset
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) ev_wr_q <= 1'b0;
		else if (wr_done && PADDR_I[9:2] inside {8'h07, 8'h08, 8'h09}) ev_wr_q <= 1'b1;
	end
	// a release of the line must trace back to a recent write
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) age_q <= 3'h7;
		else if (wr_done) age_q <= 3'h0;
		else if (age_q != 3'h7) age_q <= age_q + 3'h1;
	end
	// access phase: one wait state, then a single ready
	sequence s_wait_ready;
		!PREADY_O ##1 PREADY_O ##1 !PREADY_O;
	endsequence
	chk_one_wait: assert property ($rose(PENABLE_I) && PSEL_I |-> s_wait_ready)
		else $error("ready not after exactly one wait state");
	chk_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
		else $error("ready outside an access phase");
	chk_unmapped_err: assert property (PREADY_O && (PADDR_I[11:10] != 2'b00
		|| !(PADDR_I[9:2] inside {[8'h07:8'h0c], [8'h11:8'h14]})) |-> PSLVERR_O)
		else $error("unmapped access without error");
	chk_read_high_zero: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
		else $error("read data above bit 7 not zero");
	chk_mask_reserved: assert property (PREADY_O && !PWRITE_I && PADDR_I == 12'h028
		|-> PRDATA_O[7:5] == 3'h0)
		else $error("reserved system mask bits not zero");
	chk_mask_pins: assert property (wr_done && PADDR_I == 12'h028
		|-> ##2 SYSTEM_MASK_O == $past(PWDATA_I[4:0], 2))
		else $error("system mask pins do not follow the write");
	chk_startup_hold: assert property (!ev_wr_q |-> INTERRUPT_REQUEST_LINE_N_O)
		else $error("irq line active before first clearing write");
	chk_release_cause: assert property ($rose(INTERRUPT_REQUEST_LINE_N_O) |-> age_q <= 3'h3)
		else $error("irq line released without a host write");
endmodule
bind pmic_event_irq_logic pmic_irq_props pmic_irq_props_inst (
	.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.INTERRUPT_REQUEST_LINE_N_O(INTERRUPT_REQUEST_LINE_N_O), .SYSTEM_MASK_O(SYSTEM_MASK_O)
);

// file: tb/apb_host_model.sv
// host side: apb master that reads events and clears them by write-back
// assumes its tasks are called from one process only
`timescale 1ns/1ps
module apb_host_model (
	input wire logic clk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	// idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end
	// setup, access held until ready, then release
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= {2'b00, idx, 2'b00};
		pwdata_o <= {24'h0, wd};
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 16);
		ok = (pready_i === 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines carry the inverse, never the stale value
		paddr_o <= ~paddr_o;
		pwdata_o <= ~pwdata_o;
	endtask
	// read an event register, write the same value back
	task automatic clear(input logic [7:0] idx, output logic [31:0] rd, output logic ok);
		logic e, ok2;
		logic [31:0] x;
		xfer(1'b0, idx, 8'h00, rd, e, ok);
		xfer(1'b1, idx, rd[7:0], x, e, ok2);
		ok = ok & ok2;
	endtask
endmodule

// file: tb/pmic_event_irq_logic_bench.sv
// self-checking bench: host model on apb, monitor levels from here
// assumes a 20 cycle ldo dwell in place of the full count
`timescale 1ns/1ps
module pmic_event_irq_logic_bench
	import pmic_irq_pkg::*;
;
	localparam int unsigned LIM = 20; // shortened ldo dwell
	localparam logic [7:0] ON_SET = 8'hdf; // supply bits set when source rises
	localparam logic [7:0] OFF_SET = 8'h64; // supply bits set when source falls
	logic clk = 1'b0;
	logic rst = 1'b1;
	monitor_s mon = '0; // all monitor levels
	logic psel, pen, pwr, rdy, err, irq_n, last_err;
	logic [11:0] addr;
	logic [31:0] wdat, rdat;
	logic [4:0] smask;
	int failures = 0;
	int comparisons = 0;
	// 100 mhz clock
	always #5 clk = ~clk;
	pmic_event_irq_logic #(.LDO_LIMIT_CYCLES(LIM)) pmic_event_irq_logic_inst (
		.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(addr), .PWDATA_I(wdat), .MON_I(mon), .PRDATA_O(rdat), .PREADY_O(rdy),
		.PSLVERR_O(err), .INTERRUPT_REQUEST_LINE_N_O(irq_n), .SYSTEM_MASK_O(smask)
	);
	apb_host_model apb_host_model_inst (
		.clk_i(clk), .prdata_i(rdat), .pready_i(rdy), .pslverr_i(err), .psel_o(psel),
		.penable_o(pen), .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wdat)
	);
	task automatic finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chkl(input logic e);
		chk("irq line", {31'h0, e}, {31'h0, irq_n});
	endtask
	// a hung bus ends the run
	task automatic tmo(input logic ok);
		if (ok !== 1'b1) begin
			failures++;
			$display("[ERR] pready expected 1 seen %b", ok);
			finish_test();
		end
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] d);
		logic ok;
		apb_host_model_inst.xfer(1'b0, idx, 8'h00, d, last_err, ok);
		tmo(ok);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic e, ok;
		apb_host_model_inst.xfer(1'b1, idx, v, d, e, ok);
		tmo(ok);
	endtask
	// read, write back, compare the read value, let the line settle
	task automatic hc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic ok;
		apb_host_model_inst.clear(idx, d, ok);
		tmo(ok);
		chk($sformatf("event reg %h", idx), {24'h0, exp}, d);
		settle();
	endtask
	// one supply source to a level, waiting past the ldo dwell
	task automatic drv(input int b, input logic v);
		@(posedge clk);
		case (b)
			7: mon.supply_below_warn <= v;
			6: mon.supply_below_mon <= v;
			5: mon.ramp_busy <= v;
			4: mon.reg_out_of_range <= v;
			3: mon.ldo_at_limit <= {5{v}};
			2: mon.comparator_out <= v;
			1: mon.temp_high <= v;
			default: mon.charger_wake_input <= v;
		endcase
		repeat (LIM + 12) @(posedge clk);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		for (int i = 7; i <= 12; i++) begin
			rd(8'(i), d);
			chk("reset value", 32'h0, d);
		end
		chkl(1'b1);
		rd(IDX_SUMMARY, d);
		chk("summary", 32'h1, d);
	endtask
	// event before any clearing write keeps the line idle
	task automatic t_startup;
		logic [31:0] d;
		@(posedge clk);
		mon.powerup_done <= 1'b1;
		drv(1, 1'b1);
		chkl(1'b1);
		rd(IDX_SUMMARY, d);
		chk("summary", 32'h20, d & 32'h20);
		hc(IDX_EV_SUPPLY, 8'h02);
		rd(IDX_SUMMARY, d);
		chk("summary", 32'h0, d);
		drv(1, 1'b0);
		hc(IDX_EV_SUPPLY, 8'h00);
	endtask
	// every supply source both ways, odd bits masked
	task automatic t_supply;
		logic [7:0] m;
		for (int b = 0; b < 8; b++) begin
			m = b[0] ? 8'(1 << b) : 8'h00;
			wr(IDX_MASK_SUPPLY, m);
			drv(b, 1'b1);
			chkl(!(ON_SET[b] && !m[b]));
			hc(IDX_EV_SUPPLY, ON_SET[b] ? 8'(1 << b) : 8'h00);
			chkl(1'b1);
			drv(b, 1'b0);
			chkl(!(OFF_SET[b] && !m[b]));
			hc(IDX_EV_SUPPLY, OFF_SET[b] ? 8'(1 << b) : 8'h00);
		end
	endtask
	// new event lands at several offsets around a clearing write
	task automatic t_race;
		for (int d = 0; d < 5; d++) begin
			drv(6, ~mon.supply_below_mon);
			// write commits four edges in, event latches d + 3 edges in
			fork
				wr(IDX_EV_SUPPLY, 8'h40);
				begin
					repeat (d) @(posedge clk);
					mon.comparator_out <= ~mon.comparator_out;
				end
			join
			settle();
			hc(IDX_EV_SUPPLY, 8'h04);
		end
	endtask
	task automatic t_misc;
		logic [31:0] d;
		// ldo limit shorter than the dwell
		@(posedge clk);
		mon.ldo_at_limit <= 5'h04;
		repeat (LIM / 2) @(posedge clk);
		drv(3, 1'b0);
		hc(IDX_EV_SUPPLY, 8'h00);
		// measurement mode: a new measurement sets the regulator bit
		wr(IDX_CTRL, 8'h01);
		@(posedge clk);
		mon.reg_meas_ready <= 1'b1;
		settle();
		hc(IDX_EV_SUPPLY, 8'h10);
		wr(IDX_CTRL, 8'h00);
		rd(8'h20, d);
		chk("unmapped error", 32'h1, {31'h0, last_err});
		chk("unmapped data", 32'h0, d);
	endtask
	task automatic t_gi;
		@(posedge clk);
		mon.general_input <= 16'ha5c3;
		settle();
		chkl(1'b0);
		hc(IDX_EV_GI_HI, 8'ha5);
		chkl(1'b0);
		wr(IDX_EV_GI_LO, 8'h03);
		settle();
		hc(IDX_EV_GI_LO, 8'hc0);
		chkl(1'b1);
		wr(IDX_MASK_GI_LO, 8'h05);
		@(posedge clk);
		mon.adc_above_high <= 3'b101;
		mon.fast_two_wire_port_hit <= 1'b1;
		mon.domain_enable_port <= 3'b011;
		settle();
		hc(IDX_EV_GI_HI, 8'h43);
		chkl(1'b1);
		hc(IDX_EV_GI_LO, 8'h05);
		@(posedge clk);
		mon.general_input <= 16'h0000;
		mon.adc_above_high <= 3'b000;
		mon.fast_two_wire_port_hit <= 1'b0;
		mon.domain_enable_port <= 3'b000;
		settle();
		hc(IDX_EV_GI_LO, 8'h05);
		hc(IDX_EV_GI_HI, 8'h00);
		// active-low input: only a fall counts
		wr(IDX_ACT_LO, 8'h7f);
		@(posedge clk);
		mon.general_input[7] <= 1'b1;
		settle();
		hc(IDX_EV_GI_LO, 8'h00);
		@(posedge clk);
		mon.general_input[7] <= 1'b0;
		settle();
		hc(IDX_EV_GI_LO, 8'h80);
		wr(IDX_ACT_LO, 8'hff);
	endtask
	task automatic t_mask;
		logic [31:0] d;
		for (int i = 0; i < 3; i++) begin
			wr(8'(10 + i), 8'hff);
			rd(8'(10 + i), d);
			chk("mask", (i == 0) ? 32'h1f : 32'hff, d);
		end
		chk("system mask pins", 32'h1f, {27'h0, smask});
		wr(IDX_MASK_SYS, 8'h0a);
		rd(IDX_MASK_SYS, d);
		chk("system mask pins", 32'h0a, {27'h0, smask});
	endtask
	// reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_startup();
		t_supply();
		t_race();
		t_misc();
		t_gi();
		t_mask();
		finish_test();
	end
endmodule
